// *** fbtb_pkg.sv ***
/*
  Constants, field layouts and types for the fetch-address branch target buffer.
  Assumes 32-bit instruction addresses, big-endian numbering (bit 0 = msb).
*/
package fbtb_pkg;
  localparam int ADDR_W = 32;
  localparam int SETS = 128;
  localparam int WAYS = 4;
  localparam int IDX_W = 7;
  localparam int TAG_W = 23;
  localparam int TGT_W = 30;
  localparam int NIO_W = 3;
  localparam int CNT_W = 2;
  localparam int WAY_W = 2;
  // big-endian bits 21..27 are little-endian bits 10..4
  localparam int IDX_LSB = 4;
  // tag: big-endian 0..20 -> le 31..11, 28..29 -> le 3..2
  localparam int TAG_HI_LSB = 11;
  localparam int TAG_LO_LSB = 2;
  // word offset within the line: big-endian 27..29 -> le 4..2
  localparam int WORD_LSB = 2;
  localparam int LINE_LSB = 5;
  localparam int PRED_LAT = 2;
  localparam logic [CNT_W-1:0] CNT_SNT = 2'h0;
  localparam logic [CNT_W-1:0] CNT_WNT = 2'h1;
  localparam logic [CNT_W-1:0] CNT_WT = 2'h2;
  localparam logic [CNT_W-1:0] CNT_ST = 2'h3;

  typedef struct packed {
    logic valid;
    logic lock;
    logic [TAG_W-1:0] tag;
    logic [TGT_W-1:0] target;
    logic [NIO_W-1:0] next_instr_line_offset;
    logic [CNT_W-1:0] cnt;
  } entry_t;

  function automatic logic [IDX_W-1:0] addr_index(input logic [ADDR_W-1:0] a);
    return a[IDX_LSB +: IDX_W];
  endfunction : addr_index

  function automatic logic [TAG_W-1:0] addr_tag(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:TAG_HI_LSB], a[TAG_LO_LSB +: 2]};
  endfunction : addr_tag
endpackage : fbtb_pkg

// *** fbtb_victim.sv ***
/*
  Victim way choice for allocation: first invalid way, else round-robin among
  unlocked ways. Assumes flags come from the indexed set in the same cycle.
*/
module fbtb_victim import fbtb_pkg::*; (
  // set state
  input wire logic [WAYS-1:0] valid_i,
  input wire logic [WAYS-1:0] lock_i,
  input wire logic [WAY_W-1:0] rr_i,
  // choice
  output logic [WAY_W-1:0] way_o,
  output logic ok_o
);
  logic [WAY_W-1:0] w;
  always_comb begin
    way_o = '0;
    ok_o = 1'b0;
    for (int i = WAYS - 1; i >= 0; i--) begin
      w = WAY_W'(i) + rr_i;
      if (!lock_i[w]) begin
        way_o = w;
        ok_o = 1'b1;
      end
    end
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (!valid_i[i]) begin
        way_o = WAY_W'(i);
        ok_o = 1'b1;
      end
    end
  end
endmodule : fbtb_victim

// *** fbtb_top.sv ***
/*
  Fetch-address branch target buffer: two-stage next-fetch-address predictor
  with branch-unit update port and decode hold for unpredicted unconditionals.
  Assumes lookups and updates come from logic on CLK_SYS_I; one update a cycle.
*/
// Operation
// - 512 entries as 128 sets of 4 ways.
// - lookup starts from fetch address and yields the next fetch address.
// - a miss reports no taken branch; fetch stays sequential.
// - allocate only on a branch resolved taken; never on not-taken.
// - set index is fetch address bits 21-27, bit 0 most significant.
// - tag is fetch address bits 0-20 and 28-29.
// - address bits 30-31 ignored by lookup.
// - hit when tag equals any valid way of indexed set.
// - entries keyed by fetch-group start address, not branch address.
// - entry holds 23-bit tag and 30-bit target (bits 0-29).
// - entry has a valid flag and a lock flag.
// - entry holds a 2-bit saturating direction counter.
// - entry holds 3-bit line word offset of instruction after branch.
// - offset is branch word position plus one, modulo eight.
// - not-taken address substitutes offset; bits 0-26 increment when offset 000.
// - on a hit, group instructions after the branch are discarded.
// - a hit always redirects fetch, even when predicted not-taken.
// - hit predicts only the offset branch; earlier taken branch is mispredict.
// - unpredicted unconditional branch at decode holds decode until it executes.
// - held unconditional miss is fixed by fetch redirect only, no flush.
// - other unconditional mispredicts take full recovery with flush, unless a decode hold starts in the same cycle.
// - new entry counter starts strongly taken.
// - prediction takes 2 cycles; sequential request behind a hit is squashed.
// - entry resolving not-taken stays allocated.
module fbtb_top import fbtb_pkg::*; (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // control
  input wire logic PRED_EN_I,
  // fetch lookup
  input wire logic LOOKUP_VALID_I,
  input wire logic [ADDR_W-1:0] LOOKUP_ADDR_I,
  output logic PRED_VALID_O,
  output logic PRED_HIT_O,
  output logic PRED_TAKEN_O,
  output logic [ADDR_W-1:0] PRED_NEXT_ADDR_O,
  output logic [NIO_W-1:0] PRED_NEXT_INSTR_LINE_OFFSET_O,
  output logic [3:0] PRED_KEEP_O,
  output logic SQUASH_SEQ_O,
  output logic LOOKUP_STALL_O,
  // branch execution unit update
  input wire logic UPD_VALID_I,
  input wire logic [ADDR_W-1:0] UPD_FETCH_ADDR_I,
  input wire logic [ADDR_W-1:0] UPD_BRANCH_ADDR_I,
  input wire logic [ADDR_W-1:0] UPD_TARGET_I,
  input wire logic UPD_TAKEN_I,
  input wire logic UPD_LOCK_I,
  // decode hold
  input wire logic DEC_UNCOND_I,
  input wire logic DEC_PREDICTED_I,
  input wire logic EXEC_UNCOND_I,
  input wire logic EXEC_MISPRED_I,
  output logic DECODE_HOLD_O,
  output logic REDIRECT_ONLY_O,
  output logic FLUSH_O
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01
  } hold_t;

  typedef struct packed {
    logic s1_valid;
    logic [ADDR_W-1:0] s1_addr;
    logic pv;
    logic hit;
    logic taken;
    logic [ADDR_W-1:0] next_addr;
    logic [NIO_W-1:0] nio;
    logic [3:0] keep;
    logic [WAY_W-1:0] rr;
    hold_t hold;
    logic redir_only;
    logic flush;
  } state_t;

  // whole array resets, so no stale entry can hit after a reset
  entry_t mem_reg [SETS][WAYS];
  state_t st_reg;
  state_t st_next;

  logic [IDX_W-1:0] s1_idx;
  logic [IDX_W-1:0] u_idx;
  logic [TAG_W-1:0] u_tag;
  logic [WAYS-1:0] u_match;
  logic [WAYS-1:0] u_valid;
  logic [WAYS-1:0] u_lock;
  logic [WAY_W-1:0] u_way;
  logic [WAY_W-1:0] vic_way;
  logic vic_ok;
  logic u_hit;
  logic [NIO_W-1:0] u_nio;
  entry_t hit_e;
  logic s1_hit;

  function automatic logic [ADDR_W-1:0] not_taken_addr(input logic [ADDR_W-1:0] a,
                                                        input logic [NIO_W-1:0] n);
    logic [ADDR_W-LINE_LSB-1:0] line;
    line = a[ADDR_W-1:LINE_LSB];
    if (n == '0) begin
      line = line + 1'b1;
    end
    return {line, n, 2'b00};
  endfunction : not_taken_addr

  // counter msb is the taken prediction
  function automatic logic [CNT_W-1:0] step_cnt(input logic [CNT_W-1:0] c, input logic t);
    logic [CNT_W-1:0] r;
    r = c;
    if (t && c != CNT_ST) begin
      r = c + 1'b1;
    end else if (!t && c != CNT_SNT) begin
      r = c - 1'b1;
    end
    return r;
  endfunction : step_cnt

  function automatic logic entry_match(input entry_t e, input logic [TAG_W-1:0] t);
    return e.valid && e.tag == t;
  endfunction : entry_match

  // a fresh entry starts strongly taken; the lock bit is only set here
  function automatic entry_t new_entry(input logic [TAG_W-1:0] t,
                                       input logic [ADDR_W-1:0] tgt,
                                       input logic [NIO_W-1:0] n,
                                       input logic lk);
    entry_t e;
    e.valid = 1'b1;
    e.lock = lk;
    e.tag = t;
    e.target = tgt[ADDR_W-1:2];
    e.next_instr_line_offset = n;
    e.cnt = CNT_ST;
    return e;
  endfunction : new_entry

  // words of the group up to and including the predicted branch; a group
  // never crosses a line, so an offset wrapping to the next line keeps all
  function automatic logic [3:0] keep_mask(input logic [NIO_W-1:0] n,
                                           input logic [NIO_W-1:0] s);
    logic [NIO_W-1:0] span;
    logic [3:0] m;
    span = n - s;
    m = 4'hf;
    if (n != '0 && span != '0) begin
      for (int k = 0; k < 4; k++) begin
        m[k] = (NIO_W'(k) < span);
      end
    end
    return m;
  endfunction : keep_mask

  // stage-2 lookup against the set indexed by the held fetch address
  assign s1_idx = addr_index(st_reg.s1_addr);
  always_comb begin
    s1_hit = 1'b0;
    hit_e = '0;
    for (int w = 0; w < WAYS; w++) begin
      // lowest matching way wins; one update port never duplicates a tag
      if (!s1_hit && entry_match(mem_reg[s1_idx][w], addr_tag(st_reg.s1_addr))) begin
        s1_hit = 1'b1;
        hit_e = mem_reg[s1_idx][w];
      end
    end
  end

  // update side
  assign u_idx = addr_index(UPD_FETCH_ADDR_I);
  assign u_tag = addr_tag(UPD_FETCH_ADDR_I);
  assign u_nio = UPD_BRANCH_ADDR_I[WORD_LSB +: NIO_W] + 3'h1;
  always_comb begin
    u_match = '0;
    u_way = '0;
    for (int w = 0; w < WAYS; w++) begin
      u_valid[w] = mem_reg[u_idx][w].valid;
      u_lock[w] = mem_reg[u_idx][w].lock;
      if (entry_match(mem_reg[u_idx][w], u_tag)) begin
        u_match[w] = 1'b1;
      end
    end
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (u_match[w]) begin
        u_way = WAY_W'(w);
      end
    end
  end
  assign u_hit = |u_match;

  // victim pointer only moves on updates, so lookups never disturb it
  fbtb_victim victim_u (
    .valid_i(u_valid),
    .lock_i(u_lock),
    .rr_i(st_reg.rr),
    .way_o(vic_way),
    .ok_o(vic_ok)
  );

  // updates borrow the lookup pipe, costing fetch one bubble
  assign LOOKUP_STALL_O = UPD_VALID_I;

  // a not-taken miss, or a taken miss in a set with every way locked, writes nothing
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int s = 0; s < SETS; s++) begin
        for (int w = 0; w < WAYS; w++) begin
          mem_reg[s][w] <= '0;
        end
      end
    end else if (UPD_VALID_I) begin
      if (u_hit) begin
        // not-taken outcome only trains the counter, the entry stays
        mem_reg[u_idx][u_way].cnt <= step_cnt(mem_reg[u_idx][u_way].cnt, UPD_TAKEN_I);
        if (UPD_TAKEN_I) begin
          mem_reg[u_idx][u_way].target <= UPD_TARGET_I[ADDR_W-1:2];
          mem_reg[u_idx][u_way].next_instr_line_offset <= u_nio;
        end
      end else if (UPD_TAKEN_I && vic_ok) begin
        mem_reg[u_idx][vic_way] <= new_entry(u_tag, UPD_TARGET_I, u_nio, UPD_LOCK_I);
      end
    end
  end

  always_comb begin
    logic [NIO_W-1:0] start_w;
    st_next = st_reg;
    start_w = st_reg.s1_addr[WORD_LSB +: NIO_W];
    // stage 1 latches the request; stage 2 answers two cycles after the lookup
    st_next.s1_valid = LOOKUP_VALID_I && !UPD_VALID_I;
    st_next.s1_addr = LOOKUP_ADDR_I;
    st_next.pv = st_reg.s1_valid;
    st_next.hit = st_reg.s1_valid && PRED_EN_I && s1_hit;
    st_next.taken = 1'b0;
    st_next.nio = hit_e.next_instr_line_offset;
    st_next.keep = 4'hf;
    st_next.next_addr = {st_reg.s1_addr[ADDR_W-1:LINE_LSB], start_w, 2'b00} + 32'h10;
    if (st_reg.s1_valid && PRED_EN_I && s1_hit) begin
      // always redirect, to target or to the fall-through address
      st_next.taken = hit_e.cnt[1];
      st_next.next_addr = hit_e.cnt[1] ? {hit_e.target, 2'b00}
                                       : not_taken_addr(st_reg.s1_addr, hit_e.next_instr_line_offset);
      st_next.keep = keep_mask(hit_e.next_instr_line_offset, start_w);
    end
    if (UPD_VALID_I) begin
      st_next.rr = st_reg.rr + 1'b1;
    end
    // decode hold for unconditional branches without a prediction
    st_next.redir_only = 1'b0;
    st_next.flush = 1'b0;
    case (st_reg.hold)
      ST_IDLE: begin
        if (DEC_UNCOND_I && !DEC_PREDICTED_I) begin
          st_next.hold = ST_HOLD;
        end else if (EXEC_UNCOND_I && EXEC_MISPRED_I) begin
          st_next.flush = 1'b1;
        end
      end
      ST_HOLD: begin
        if (EXEC_UNCOND_I) begin
          st_next.hold = ST_IDLE;
          st_next.redir_only = EXEC_MISPRED_I;
        end
      end
      default: begin
        st_next.hold = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_reg <= '{hold: ST_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign PRED_VALID_O = st_reg.pv;
  assign PRED_HIT_O = st_reg.hit;
  assign PRED_TAKEN_O = st_reg.taken;
  assign PRED_NEXT_ADDR_O = st_reg.next_addr;
  assign PRED_NEXT_INSTR_LINE_OFFSET_O = st_reg.nio;
  assign PRED_KEEP_O = st_reg.keep;
  // the sequential request behind a hitting one is already in flight
  assign SQUASH_SEQ_O = st_reg.hit;
  assign DECODE_HOLD_O = (st_reg.hold == ST_HOLD);
  assign REDIRECT_ONLY_O = st_reg.redir_only;
  assign FLUSH_O = st_reg.flush;
endmodule : fbtb_top

// *** fbtb_chk.sv ***
/*
  Assertions on the ports of fbtb_top, bound to every instance.
  Assumes one clock and an asynchronous active-low reset.
*/
module fbtb_chk import fbtb_pkg::*; (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // requests
  input wire logic PRED_EN_I,
  input wire logic LOOKUP_VALID_I,
  input wire logic [ADDR_W-1:0] LOOKUP_ADDR_I,
  input wire logic UPD_VALID_I,
  input wire logic DEC_UNCOND_I,
  input wire logic DEC_PREDICTED_I,
  input wire logic EXEC_UNCOND_I,
  input wire logic EXEC_MISPRED_I,
  // answers
  input wire logic PRED_VALID_O,
  input wire logic PRED_HIT_O,
  input wire logic PRED_TAKEN_O,
  input wire logic [ADDR_W-1:0] PRED_NEXT_ADDR_O,
  input wire logic [NIO_W-1:0] PRED_NEXT_INSTR_LINE_OFFSET_O,
  input wire logic [3:0] PRED_KEEP_O,
  input wire logic SQUASH_SEQ_O,
  input wire logic LOOKUP_STALL_O,
  input wire logic DECODE_HOLD_O,
  input wire logic REDIRECT_ONLY_O,
  input wire logic FLUSH_O
);
  logic [ADDR_W-1:0] a1_reg;
  logic [ADDR_W-1:0] a2_reg;
  // address delayed to line up with the answer; stale values are harmless, no answer is pending then
  always_ff @(posedge CLK_SYS_I) begin
    a1_reg <= LOOKUP_ADDR_I;
    a2_reg <= a1_reg;
  end
  default clocking @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);
  sequence s_hold_start;
    DEC_UNCOND_I && !DEC_PREDICTED_I && !DECODE_HOLD_O;
  endsequence
  sequence s_release;
    DECODE_HOLD_O && EXEC_UNCOND_I && EXEC_MISPRED_I;
  endsequence
  property p_lat; LOOKUP_VALID_I && !UPD_VALID_I |-> ##2 PRED_VALID_O; endproperty
  a_lat: assert property (p_lat) else $error("lookup answer late");
  property p_squash; PRED_VALID_O |-> SQUASH_SEQ_O == PRED_HIT_O; endproperty
  a_squash: assert property (p_squash) else $error("squash differs from hit");
  property p_miss; PRED_VALID_O && !PRED_HIT_O |-> !PRED_TAKEN_O && PRED_KEEP_O == 4'hf; endproperty
  a_miss: assert property (p_miss) else $error("miss not sequential");
  property p_dis; !PRED_EN_I && LOOKUP_VALID_I && !UPD_VALID_I |-> ##2 !PRED_HIT_O; endproperty
  a_dis: assert property (p_dis) else $error("hit while disabled");
  property p_miss_addr; PRED_VALID_O && !PRED_HIT_O |-> PRED_NEXT_ADDR_O == (a2_reg & ~32'h3) + 32'h10; endproperty
  a_miss_addr: assert property (p_miss_addr) else $error("miss next address");
  property p_nt_addr;
    PRED_VALID_O && PRED_HIT_O && !PRED_TAKEN_O |-> PRED_NEXT_ADDR_O ==
      {a2_reg[31:5] + 27'(PRED_NEXT_INSTR_LINE_OFFSET_O == 3'h0), PRED_NEXT_INSTR_LINE_OFFSET_O, 2'h0};
  endproperty
  a_nt_addr: assert property (p_nt_addr) else $error("fall-through address");
  property p_hold_on; s_hold_start |=> DECODE_HOLD_O; endproperty
  a_hold_on: assert property (p_hold_on) else $error("decode hold missing");
  property p_hold_keep; DECODE_HOLD_O && !EXEC_UNCOND_I |=> DECODE_HOLD_O && !FLUSH_O; endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("decode hold dropped");
  property p_redir; s_release |=> REDIRECT_ONLY_O && !FLUSH_O && !DECODE_HOLD_O; endproperty
  a_redir: assert property (p_redir) else $error("held branch not redirect-only");
  property p_flush;
    !DECODE_HOLD_O && EXEC_UNCOND_I && EXEC_MISPRED_I && !(DEC_UNCOND_I && !DEC_PREDICTED_I) |=> FLUSH_O && !REDIRECT_ONLY_O;
  endproperty
  a_flush: assert property (p_flush) else $error("mispredict without flush");
  property p_stall; LOOKUP_STALL_O == UPD_VALID_I; endproperty
  a_stall: assert property (p_stall) else $error("update does not stall lookup");
endmodule : fbtb_chk

bind fbtb_top fbtb_chk u_chk (.*);

// *** fbtb_part.sv ***
/*
  Stand-in for the fetch unit and the branch execution unit.
  Assumes the caller enters its tasks after reset, one at a time.
*/
module fbtb_part import fbtb_pkg::*; (
  // clock
  input wire logic clk_i,
  // fetch lookup
  output logic lk_valid_o,
  output logic [ADDR_W-1:0] lk_addr_o,
  // branch execution unit update
  output logic upd_valid_o,
  output logic [ADDR_W-1:0] upd_fetch_o,
  output logic [ADDR_W-1:0] upd_branch_o,
  output logic [ADDR_W-1:0] upd_target_o,
  output logic upd_taken_o,
  output logic upd_lock_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {lk_valid_o, upd_valid_o, upd_taken_o, upd_lock_o} = 4'h0;
    {lk_addr_o, upd_fetch_o, upd_branch_o, upd_target_o} = '0;
  end
  task automatic look(input logic [ADDR_W-1:0] a);
    @(posedge clk_i);
    #1;
    lk_valid_o = 1'b1;
    lk_addr_o = a;
    @(posedge clk_i);
    #1;
    lk_valid_o = 1'b0;
    // released lines flip so a stale value is never trusted
    lk_addr_o = ~a;
  endtask : look
  // only source of updates, one per executed branch, not-taken ones too
  task automatic upd(input logic [ADDR_W-1:0] f, b, t, input logic tk, lk);
    @(posedge clk_i);
    #1;
    {upd_valid_o, upd_taken_o, upd_lock_o} = {1'b1, tk, lk};
    {upd_fetch_o, upd_branch_o, upd_target_o} = {f, b, t};
    @(posedge clk_i);
    #1;
    upd_valid_o = 1'b0;
    {upd_fetch_o, upd_branch_o, upd_target_o} = ~{f, b, t};
  endtask : upd
endmodule : fbtb_part

// *** fetch_address_branch_target_buffer_tb.sv ***
/*
  Self-checking bench for fbtb_top, driven through fbtb_part.
  Assumes fbtb_pkg, fbtb_top, fbtb_part and fbtb_chk compiled before it.
*/
module fetch_address_branch_target_buffer_tb import fbtb_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic hit;
    logic tk;
    logic [ADDR_W-1:0] nxt;
    logic [3:0] keep;
  } look_row_t;
  // set 0: 0x1000, 0x3008; set 1: 0x101c; set 2: four locked ways
  look_row_t rows [10] = '{'{32'h1000, 1'b1, 1'b1, 32'h100c, 4'h3}, '{32'h1003, 1'b1, 1'b1, 32'h100c, 4'h3},
    '{32'h1004, 1'b0, 1'b0, 32'h1014, 4'hf}, '{32'h1008, 1'b0, 1'b0, 32'h1018, 4'hf},
    '{32'h2000, 1'b0, 1'b0, 32'h2010, 4'hf}, '{32'h101c, 1'b1, 1'b0, 32'h1020, 4'hf},
    '{32'h3008, 1'b1, 1'b0, 32'h3014, 4'h7}, '{32'h4020, 1'b1, 1'b1, 32'h0a00, 4'h3},
    '{32'h5820, 1'b1, 1'b1, 32'h0d00, 4'h3}, '{32'h6020, 1'b0, 1'b0, 32'h6030, 4'hf}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pred_en = 1'b1;
  logic dec_unc = 1'b0, dec_prd = 1'b0, ex_unc = 1'b0, ex_mis = 1'b0;
  logic lk_v, upd_v, upd_tk, upd_lk, p_v, hit, tk, sq, hold, redir, flush;
  logic [ADDR_W-1:0] lk_a, upd_f, upd_b, upd_t, nxt;
  logic [3:0] keep;
  int n_mismatch = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  fbtb_part part (.clk_i(clk), .lk_valid_o(lk_v), .lk_addr_o(lk_a), .upd_valid_o(upd_v), .upd_fetch_o(upd_f),
    .upd_branch_o(upd_b), .upd_target_o(upd_t), .upd_taken_o(upd_tk), .upd_lock_o(upd_lk));
  fbtb_top dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PRED_EN_I(pred_en), .LOOKUP_VALID_I(lk_v), .LOOKUP_ADDR_I(lk_a),
    .PRED_VALID_O(p_v), .PRED_HIT_O(hit), .PRED_TAKEN_O(tk), .PRED_NEXT_ADDR_O(nxt),
    .PRED_NEXT_INSTR_LINE_OFFSET_O(), .PRED_KEEP_O(keep), .SQUASH_SEQ_O(sq), .LOOKUP_STALL_O(),
    .UPD_VALID_I(upd_v), .UPD_FETCH_ADDR_I(upd_f), .UPD_BRANCH_ADDR_I(upd_b), .UPD_TARGET_I(upd_t),
    .UPD_TAKEN_I(upd_tk), .UPD_LOCK_I(upd_lk), .DEC_UNCOND_I(dec_unc), .DEC_PREDICTED_I(dec_prd),
    .EXEC_UNCOND_I(ex_unc), .EXEC_MISPRED_I(ex_mis), .DECODE_HOLD_O(hold), .REDIRECT_ONLY_O(redir), .FLUSH_O(flush));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  task automatic answer(input logic [ADDR_W-1:0] a);
    part.look(a);
    @(posedge clk);
    #1;
  endtask : answer
  initial begin
    #500000;
    n_mismatch++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    chk({p_v, hold, keep}, 6'h0);
    rst_n = 1'b1;
    part.upd(32'h1000, 32'h1004, 32'h100c, 1'b1, 1'b0);
    part.upd(32'h2000, 32'h2004, 32'h2100, 1'b0, 1'b0);
    // one taken allocation, then two not-taken steps
    for (int j = 0; j < 3; j++) begin
      part.upd(32'h101c, 32'h101c, 32'h2000, j == 0, 1'b0);
      part.upd(32'h3008, 32'h3010, 32'h4000, j == 0, 1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      part.upd(32'h4020 + 32'(i) * 32'h800, 32'h4024 + 32'(i) * 32'h800, 32'h0a00 + 32'(i) * 32'h100, 1'b1, i < 4);
    end
    foreach (rows[k]) begin
      answer(rows[k].a);
      chk(p_v, 1'b1);
      chk(hit, rows[k].hit);
      chk(tk, rows[k].tk);
      chk(nxt, rows[k].nxt);
      chk(keep, rows[k].keep);
      chk(sq, rows[k].hit);
    end
    pred_en = 1'b0;
    answer(32'h1000);
    chk({hit, nxt}, 33'h001010);
    pred_en = 1'b1;
    // a predicted unconditional must not hold decode
    {dec_unc, dec_prd} = 2'h3;
    @(posedge clk);
    #1;
    chk(hold, 1'b0);
    dec_prd = 1'b0;
    @(posedge clk);
    #1;
    dec_unc = 1'b0;
    chk(hold, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk(hold, 1'b1);
    {ex_unc, ex_mis} = 2'h3;
    @(posedge clk);
    #1;
    chk({hold, redir, flush}, 3'h2);
    @(posedge clk);
    #1;
    {ex_unc, ex_mis} = 2'h0;
    chk({hold, redir, flush}, 3'h1);
    // second reset in mid-run wipes every entry
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    chk({p_v, hold, keep}, 6'h0);
    rst_n = 1'b1;
    answer(32'h1000);
    chk({p_v, hit}, 2'h2);
    summarize;
  end
endmodule : fetch_address_branch_target_buffer_tb
